// File: sbc_dev.sv
// counter end: measurement, latches, scan multiplexer and rear control lines
// Behaviour
// - marker low one scan period, falls on rise
// - rise ending marker presents most significant digit
// - bcd lines 8 4 2 1, high is one
// - digits msd to lsd, one per slot
// - all bcd lines high in marker slot
// - dp strobe high during slot of marked digit
// - about 5 kHz scan, advance each rise
// - far end captures on following falling edge
// - latch pulse spans gate plus display, latch falling
// - far end samples only after latch falling edge; sbc_host captures every frame and flags the edge on latch_evt_o
// - overflow output high while counter overflowed
// - low reset line clears counter; device drives it
// - power-up pulses reset line, internal clears do not
// - gate output high while counting
// - rear source, start high begins one measurement
// - start held high measures continuously
// - identify low while rear source selected and option functions not enabled
// - option: start begins cycle, option gate low
// - option identify low continuous, high on command
// - source identify low enables option functions
// - option gate low throughout measurement interval
// - external 1, 5, 10 MHz reference replaces timebase
`timescale 1ns/1ps
module sbc_dev import sbc_pkg::*; #(
   parameter int NDIG       = NDIG_DEF,
   parameter bit OPT_FITTED = 1'b0,
   parameter int GATE_TK    = GATE_TICKS,
   parameter int DISP_CY    = DISP_CYC,
   parameter int SCAN_HALF  = SCAN_HALF_CYC
) (
   input  wire logic           clk_sys_i,     // instrument clock
   input  wire logic           clk_link_i,    // link clock for the scan logic
   input  wire logic           nrst_i,        // synchronous reset, active low
   input  wire logic           sig_i,         // measured signal pin
   input  wire logic           ext_ref_i,     // external reference pin
   input  wire logic           ext_sel_i,     // jumper: use external reference
   input  wire sbc_ext_e       ext_freq_i,    // jumper: reference frequency
   input  wire logic           src_rear_i,    // source switch at rear input
   input  wire logic           rst_btn_i,     // front reset or control between detents
   input  wire logic [3:0]     dp_pos_i,      // digit slot with active point, 0 none
   output logic [4*NDIG-1:0]   disp_o,        // latched display, msd high
   sbc_link_if.dev             lnk            // rear pins
);
   localparam int DW = 4 * NDIG;

   // ==========================================================
   // parameter check
   if (NDIG < 1 || NDIG > 15 || SCAN_HALF < 1 || SCAN_HALF > 2047 || GATE_TK < 1) begin : g_chk
      $error("sbc_dev: unsupported parameter value");
   end

   // ==========================================================
   // instrument domain
   typedef struct packed {
      logic [1:0]    sig_s;
      logic          sig_d;
      logic [1:0]    ref_s;
      logic          ref_d;
      logic [1:0]    rst_s;
      logic [1:0]    start_s;
      logic [1:0]    sid_s;
      logic [1:0]    ack_s;
      logic [1:0]    rear_s;
      sbc_meas_e     st;
      logic [31:0]   left;
      logic [4:0]    acc;
      logic [DW-1:0] cnt;
      logic          cnt_ovf;
      logic [DW-1:0] disp;
      logic          disp_ovf;
      logic          dirty;
      logic [DW+3:0] xfer;
      logic          req;
      logic [7:0]    pwr;
   } sys_s;
   sys_s sys_q, next_sys;

   // link domain state, declared early as the instrument side reads its ack
   typedef struct packed {
      logic [1:0]    lrst;
      logic [1:0]    req_s;
      logic          ack;
      logic [DW+3:0] ldat;
      logic [10:0]   div;
      logic          sclk;
      logic [3:0]    slot;
      logic          mark_n;
      logic [3:0]    bcd;
      logic          dp;
   } lnk_s;
   lnk_s lnk_q, next_lnk;

   // ==========================================================
   // bcd increment chain
   logic [DW-1:0] cnt_inc;
   logic [NDIG:0] carry;
   assign carry[0] = 1'b1;
   for (genvar d = 0; d < NDIG; d++) begin : g_inc
      logic [3:0] dig;
      assign dig              = sys_q.cnt[4*d +: 4];
      assign cnt_inc[4*d +: 4] = !carry[d] ? dig : (dig == 4'h9) ? 4'h0 : dig + 4'h1;
      assign carry[d+1]        = carry[d] && (dig == 4'h9);
   end

   logic opt_en, rear_cmd, run_ok, tb_tick;
   logic [3:0] tb_w;
   always_comb begin
      next_sys = sys_q;
      next_sys.sig_s   = {sys_q.sig_s[0], sig_i};
      next_sys.sig_d   = sys_q.sig_s[1];
      next_sys.ref_s   = {sys_q.ref_s[0], ext_ref_i};
      next_sys.ref_d   = sys_q.ref_s[1];
      next_sys.rst_s   = {sys_q.rst_s[0], lnk.rst_line};
      next_sys.start_s = {sys_q.start_s[0], lnk.start};
      next_sys.sid_s   = {sys_q.sid_s[0], lnk.src_ident};
      next_sys.ack_s   = {sys_q.ack_s[0], lnk_q.ack};
      next_sys.rear_s  = {sys_q.rear_s[0], src_rear_i};
      opt_en   = OPT_FITTED && !sys_q.sid_s[1];
      rear_cmd = sys_q.rear_s[1];
      run_ok   = !rear_cmd || sys_q.start_s[1];
      // timebase tick, internal 10 MHz or external reference
      tb_tick = 1'b0;
      tb_w    = W_10M;
      if (ext_sel_i) begin
         tb_tick = sys_q.ref_s[1] && !sys_q.ref_d;
         unique case (ext_freq_i)
            SBC_EXT_1M: tb_w = W_1M;
            SBC_EXT_5M: tb_w = W_5M;
            default:    tb_w = W_10M;
         endcase
      end else if (5'(sys_q.acc + TB_ACC_ADD) >= 5'(TB_ACC_MOD)) begin
         tb_tick      = 1'b1;
         next_sys.acc = 5'(sys_q.acc + TB_ACC_ADD - TB_ACC_MOD);
      end else begin
         next_sys.acc = 5'(sys_q.acc + TB_ACC_ADD);
      end
      if (sys_q.pwr != 8'h0) begin
         next_sys.pwr = sys_q.pwr - 8'h1;
      end
      unique case (sys_q.st)
         SBC_IDLE: begin
            if (run_ok) begin
               next_sys.st      = SBC_GATE;
               next_sys.left    = 32'(GATE_TK);
               next_sys.cnt     = '0;                               // internal clear, line untouched
               next_sys.cnt_ovf = 1'b0;
            end
         end
         SBC_GATE: begin
            if (sys_q.sig_s[1] && !sys_q.sig_d) begin
               next_sys.cnt = cnt_inc;
               if (carry[NDIG]) begin
                  next_sys.cnt_ovf = 1'b1;
               end
            end
            if (tb_tick) begin
               if (sys_q.left <= 32'(tb_w)) begin
                  next_sys.st   = SBC_DISP;
                  next_sys.left = 32'(DISP_CY);
               end else begin
                  next_sys.left = sys_q.left - 32'(tb_w);
               end
            end
         end
         SBC_DISP: begin
            if (sys_q.left <= 32'h1) begin
               next_sys.st       = SBC_IDLE;
               next_sys.disp     = sys_q.cnt;
               next_sys.disp_ovf = sys_q.cnt_ovf;
               next_sys.dirty    = 1'b1;
            end else begin
               next_sys.left = sys_q.left - 32'h1;
            end
         end
         default: next_sys.st = SBC_IDLE;
      endcase
      if (!sys_q.rst_s[1]) begin
         next_sys.st      = SBC_IDLE;
         next_sys.cnt     = '0;
         next_sys.cnt_ovf = 1'b0;
      end
      // hand the display and point position to the scan domain
      if (sys_q.dirty && (sys_q.req == sys_q.ack_s[1])) begin
         next_sys.xfer  = {dp_pos_i, sys_q.disp};
         next_sys.req   = !sys_q.req;
         next_sys.dirty = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         sys_q      <= '0;
         sys_q.st   <= SBC_IDLE;
         sys_q.pwr  <= 8'(PWRUP_CYC);
         sys_q.rst_s <= 2'h3;
         sys_q.sid_s <= 2'h3;
         sys_q.rear_s <= 2'h3;
      end else begin
         sys_q <= next_sys;
      end
   end

   // ==========================================================
   // pin outputs from the instrument domain
   assign disp_o          = sys_q.disp;
   assign lnk.gate        = (sys_q.st == SBC_GATE);
   assign lnk.data_good   = (sys_q.st != SBC_IDLE);
   assign lnk.ovf         = sys_q.disp_ovf;
   assign lnk.cnt_ident   = opt_en || !rear_cmd;
   assign lnk.opt_ident   = !opt_en || rear_cmd;
   assign lnk.opt_gate    = !(opt_en && (lnk.gate || sys_q.start_s[1]));
   assign lnk.rst_dev_out = 1'b0;
   assign lnk.rst_dev_oe  = (sys_q.pwr != 8'h0) || rst_btn_i;

   // ==========================================================
   // link domain: scan clock divider and digit multiplexer

   always_comb begin
      next_lnk       = lnk_q;
      next_lnk.lrst  = {lnk_q.lrst[0], nrst_i};
      next_lnk.req_s = {lnk_q.req_s[0], sys_q.req};
      if (lnk_q.req_s[1] != lnk_q.ack) begin
         next_lnk.ldat = sys_q.xfer;
         next_lnk.ack  = lnk_q.req_s[1];
      end
      if (lnk_q.div >= 11'(SCAN_HALF - 1)) begin
         next_lnk.div  = '0;
         next_lnk.sclk = !lnk_q.sclk;
         if (!lnk_q.sclk) begin
            next_lnk.slot = (lnk_q.slot >= 4'(NDIG)) ? 4'h0 : lnk_q.slot + 4'h1;
            if (next_lnk.slot == 4'h0) begin
               next_lnk.mark_n = 1'b0;
               next_lnk.bcd    = BCD_MARK;
               next_lnk.dp     = 1'b0;
            end else begin
               next_lnk.mark_n = 1'b1;
               next_lnk.bcd    = lnk_q.ldat[4*(NDIG - int'(next_lnk.slot)) +: 4];
               next_lnk.dp     = (lnk_q.ldat[DW +: 4] == next_lnk.slot);
            end
         end
      end else begin
         next_lnk.div = lnk_q.div + 11'h1;
      end
   end

   always_ff @(posedge clk_link_i) begin
      if (!lnk_q.lrst[1]) begin
         lnk_q        <= '0;
         lnk_q.lrst   <= next_lnk.lrst;
         lnk_q.slot   <= 4'(NDIG);
         lnk_q.mark_n <= 1'b1;
      end else begin
         lnk_q <= next_lnk;
      end
   end

   assign lnk.scan_clk          = lnk_q.sclk;
   assign lnk.scan_frame_marker = lnk_q.mark_n;
   assign lnk.bcd               = lnk_q.bcd;
   assign lnk.dp                = lnk_q.dp;
endmodule // sbc_dev

// File: sbc_pkg.sv
// shared constants and types for the scanned bcd counter output link
package sbc_pkg;
   // ==========================================================
   // clocks and times
   localparam int SYS_HZ        = 125_000_000;
   localparam int LINK_HZ       = 15_625_000;
   localparam int SCAN_HZ       = 5_000;
   localparam int SCAN_HALF_CYC = LINK_HZ / (2 * SCAN_HZ);
   localparam int TB_INT_HZ     = 10_000_000;
   localparam int TB_ACC_ADD    = 2;
   localparam int TB_ACC_MOD    = SYS_HZ * TB_ACC_ADD / TB_INT_HZ;
   localparam int TB_TICK_NS    = 1_000_000_000 / TB_INT_HZ;
   localparam int GATE_NS       = 1_000_000;
   localparam int GATE_TICKS    = GATE_NS / TB_TICK_NS;
   localparam int DISP_NS       = 1_000_000;
   localparam int DISP_CYC      = DISP_NS * (SYS_HZ / 1_000_000) / 1000;
   localparam int PWRUP_NS      = 1_000;
   localparam int PWRUP_CYC     = PWRUP_NS * (SYS_HZ / 1_000_000) / 1000;
   // ==========================================================
   // display
   localparam int NDIG_DEF      = 8;
   localparam logic [3:0] BCD_MARK = 4'hf;
   // ==========================================================
   // external reference frequency jumper, weight in timebase ticks
   typedef enum logic [1:0] {
      SBC_EXT_1M  = 2'h0,
      SBC_EXT_5M  = 2'h1,
      SBC_EXT_10M = 2'h2
   } sbc_ext_e;
   localparam logic [3:0] W_1M  = 4'ha;
   localparam logic [3:0] W_5M  = 4'h2;
   localparam logic [3:0] W_10M = 4'h1;
   // ==========================================================
   // measurement states
   typedef enum logic [2:0] {
      SBC_IDLE = 3'b001,
      SBC_GATE = 3'b010,
      SBC_DISP = 3'b100
   } sbc_meas_e;
endpackage

// File: sbc_link_if.sv
// rear interface pins between the counter and the demultiplexing equipment
`timescale 1ns/1ps
interface sbc_link_if;
   logic       scan_clk;           // scan clock, made by the counter
   logic       scan_frame_marker;  // low during the marker slot
   logic [3:0] bcd;                // digit, weights 8 4 2 1
   logic       dp;                 // decimal point strobe
   logic       data_good;          // latch-update pulse
   logic       ovf;                // overflow
   logic       gate;               // counting gate open
   logic       cnt_ident;          // counter identify, low = on command
   logic       opt_ident;          // option counter identify
   logic       opt_gate;           // option gate, low while measuring
   logic       start;              // start count, from far end
   logic       src_ident;          // source identify, low enables option
   logic       rst_dev_out;        // reset line drive value, counter
   logic       rst_dev_oe;         // counter pulls reset line
   logic       rst_host_out;       // reset line drive value, far end
   logic       rst_host_oe;        // far end pulls reset line
   logic       rst_line;           // resolved reset line level
   // open-drain line with pull-up
   assign rst_line = !((rst_dev_oe && !rst_dev_out) || (rst_host_oe && !rst_host_out));
   modport dev (output scan_clk, scan_frame_marker, bcd, dp, data_good, ovf, gate,
                cnt_ident, opt_ident, opt_gate, rst_dev_out, rst_dev_oe,
                input start, src_ident, rst_line);
   modport host (input scan_clk, scan_frame_marker, bcd, dp, data_good, ovf, gate,
                 cnt_ident, opt_ident, opt_gate, rst_line,
                 output start, src_ident, rst_host_out, rst_host_oe);
endinterface

// File: sbc_host.sv
// far end: demultiplexes the scanned digits and drives the command lines
`timescale 1ns/1ps
module sbc_host import sbc_pkg::*; #(
   parameter int NDIG = NDIG_DEF
) (
   input  wire logic         clk_sys_i,     // local clock
   input  wire logic         nrst_i,        // synchronous reset, active low
   input  wire logic         start_i,       // request measurement
   input  wire logic         opt_en_i,      // enable option functions
   input  wire logic         rst_req_i,     // pull counter reset line
   output logic [4*NDIG-1:0] digits_o,      // last full frame, msd high
   output logic [3:0]        dp_slot_o,     // slot of decimal point, 0 none
   output logic              frame_o,       // one-cycle pulse, new frame
   output logic              latch_evt_o,   // one-cycle pulse, latch update fell
   output logic              ovf_o,         // overflow level
   output logic              gate_o,        // counting gate level
   output logic              rst_seen_o,    // reset line is low
   sbc_link_if.host          lnk            // rear pins
);
   localparam int DW = 4 * NDIG;
   if (NDIG < 1 || NDIG > 15) begin : g_chk
      $error("sbc_host: unsupported digit count");
   end

   typedef struct packed {
      logic [1:0]    sclk_s;
      logic          sclk_d;
      logic [1:0]    mark_s;
      logic [1:0][3:0] bcd_s;
      logic [1:0]    dp_s;
      logic [1:0]    dg_s;
      logic          dg_d;
      logic [1:0]    ovf_s;
      logic [1:0]    gate_s;
      logic [1:0]    rst_s;
      logic [3:0]    slot;
      logic [DW-1:0] acc;
      logic [3:0]    dpa;
      logic [DW-1:0] dig;
      logic [3:0]    dps;
      logic          frame;
      logic          lev;
   } hst_s;
   hst_s q, next_q;

   always_comb begin
      next_q        = q;
      next_q.sclk_s = {q.sclk_s[0], lnk.scan_clk};
      next_q.sclk_d = q.sclk_s[1];
      next_q.mark_s = {q.mark_s[0], lnk.scan_frame_marker};
      next_q.bcd_s  = {q.bcd_s[0], lnk.bcd};
      next_q.dp_s   = {q.dp_s[0], lnk.dp};
      next_q.dg_s   = {q.dg_s[0], lnk.data_good};
      next_q.dg_d   = q.dg_s[1];
      next_q.ovf_s  = {q.ovf_s[0], lnk.ovf};
      next_q.gate_s = {q.gate_s[0], lnk.gate};
      next_q.rst_s  = {q.rst_s[0], lnk.rst_line};
      next_q.frame  = 1'b0;
      next_q.lev    = !q.dg_s[1] && q.dg_d;
      // capture on the scan clock falling edge
      if (!q.sclk_s[1] && q.sclk_d) begin
         if (!q.mark_s[1]) begin
            next_q.slot = 4'h1;
            next_q.dpa  = 4'h0;
         end else if (q.slot != 4'h0) begin
            next_q.acc = {q.acc[DW-5:0], q.bcd_s[1]};
            if (q.dp_s[1]) begin
               next_q.dpa = q.slot;
            end
            if (q.slot == 4'(NDIG)) begin
               next_q.slot  = 4'h0;
               next_q.dig   = {q.acc[DW-5:0], q.bcd_s[1]};
               next_q.dps   = q.dp_s[1] ? q.slot : q.dpa;
               next_q.frame = 1'b1;
            end else begin
               next_q.slot = q.slot + 4'h1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign digits_o         = q.dig;
   assign dp_slot_o        = q.dps;
   assign frame_o          = q.frame;
   assign latch_evt_o      = q.lev;
   assign ovf_o            = q.ovf_s[1];
   assign gate_o           = q.gate_s[1];
   assign rst_seen_o       = !q.rst_s[1];
   assign lnk.start        = start_i;
   assign lnk.src_ident    = !opt_en_i;
   assign lnk.rst_host_out = 1'b0;
   assign lnk.rst_host_oe  = rst_req_i;
endmodule // sbc_host

// File: sbc_asserts.sv
// concurrent checks on the rear link between counter and far end
`timescale 1ns/1ps
module sbc_asserts import sbc_pkg::*; #(
   parameter int NDIG = NDIG_DEF
) (
   input wire logic       clk_sys_i,         // instrument clock
   input wire logic       clk_link_i,        // link clock
   input wire logic       nrst_i,            // reset, active low
   input wire logic       scan_clk,          // scan clock
   input wire logic       scan_frame_marker, // marker slot, low
   input wire logic [3:0] bcd,               // digit lines
   input wire logic       dp,                // point strobe
   input wire logic       data_good,         // latch pulse
   input wire logic       gate,              // gate open
   input wire logic       rst_line           // reset line level
);
   // ==========================================================
   // rises counted since the marker fell
   logic       sc_q;
   logic       seen;
   logic [4:0] rises;
   always_ff @(posedge clk_link_i) begin
      if (!nrst_i) begin
         sc_q  <= 1'b0;
         seen  <= 1'b0;
         rises <= 5'h0;
      end else begin
         sc_q <= scan_clk;
         if (scan_clk && !sc_q) begin
            seen  <= seen || !scan_frame_marker;
            rises <= scan_frame_marker ? rises + 5'h1 : 5'h0;
         end
      end
   end
   // ==========================================================
   // scan timing, half period of 8 link cycles
   sequence s_rise;
      $rose(scan_clk);
   endsequence
   sequence s_period;
      scan_clk [*8] ##1 !scan_clk [*8] ##1 scan_clk;
   endsequence
   sequence s_slot;
      !scan_frame_marker [*8] ##1 !scan_frame_marker [*8] ##1 scan_frame_marker;
   endsequence
   chk_marker_edge: assert property (
      @(posedge clk_link_i) disable iff (!nrst_i) $changed(scan_frame_marker) |-> s_rise)
      else $error("marker moved off a scan rise");
   chk_marker_width: assert property (
      @(posedge clk_link_i) disable iff (!nrst_i) $fell(scan_frame_marker) |-> s_slot)
      else $error("marker slot not one scan period");
   chk_marker_bcd: assert property (
      @(posedge clk_link_i) disable iff (!nrst_i) !scan_frame_marker |-> bcd == BCD_MARK && !dp)
      else $error("digit lines not high in marker slot");
   chk_bcd_on_rise: assert property (
      @(posedge clk_link_i) disable iff (!nrst_i) $changed(bcd) || $changed(dp) |-> s_rise)
      else $error("digit changed off a scan rise");
   chk_scan_period: assert property (
      @(posedge clk_link_i) disable iff (!nrst_i) $rose(scan_clk) |-> s_period)
      else $error("scan clock period wrong");
   chk_dp_slot: assert property (
      @(posedge clk_link_i) disable iff (!nrst_i) $rose(dp) |-> dp [*8] ##1 dp [*8] ##1 !dp)
      else $error("point strobe not one slot");
   chk_frame_slots: assert property (
      @(posedge clk_link_i) disable iff (!nrst_i) $fell(scan_frame_marker) && seen |->
      rises == NDIG)
      else $error("frame slot count wrong");
   chk_gate_in_pulse: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i) gate |-> data_good)
      else $error("gate open outside latch pulse");
   chk_pulse_start: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i) $rose(gate) || $rose(data_good) |->
      $rose(gate) && $rose(data_good))
      else $error("gate and latch pulse start apart");
   chk_disp_tail: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i) $fell(gate) && rst_line |-> data_good [*8])
      else $error("latch pulse lacks display time");
   chk_line_abort: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i) !rst_line [*6] |-> !gate && !data_good)
      else $error("low reset line did not stop count");
endmodule // sbc_asserts

// File: scanned_bcd_counter_output_bench.sv
// bench joining the counter end and the far end across the rear link
`timescale 1ns/1ps
module scanned_bcd_counter_output_bench import sbc_pkg::*;;
   localparam int ND = 4;
   localparam int GT = 20;
   logic            clk_sys_i  = 1'b0;
   logic            clk_link_i = 1'b0;
   logic            nrst_i     = 1'b0;
   logic            sig_i      = 1'b0;
   logic            ext_sel_i  = 1'b0;
   sbc_ext_e        ext_freq_i = SBC_EXT_10M;
   logic            src_rear_i = 1'b1;
   logic            rst_btn_i  = 1'b0;
   logic [3:0]      dp_pos_i   = 4'h0;
   logic            start_i    = 1'b0;
   logic            rst_req_i  = 1'b0;
   logic            opt_en     = 1'b0;
   logic [3:0]      ref_cnt    = 4'h0;
   logic [4*ND-1:0] disp;
   logic [4*ND-1:0] digits;
   logic [3:0]      dp_slot;
   logic            frame;
   logic            rst_seen;
   logic            gate_h;
   logic            ovf_h;
   logic            latch_evt;
   int              failures    = 0;
   int              comparisons = 0;
   int              cyc         = 0;
   always #4 clk_sys_i = !clk_sys_i;
   always #32 clk_link_i = !clk_link_i;
   always @(posedge clk_sys_i) ref_cnt <= ref_cnt + 4'h1;
   sbc_link_if lnk ();
   sbc_dev #(.NDIG(ND), .OPT_FITTED(1'b1), .GATE_TK(GT), .DISP_CY(50), .SCAN_HALF(8)) i_sbc_dev (
      .clk_sys_i(clk_sys_i), .clk_link_i(clk_link_i), .nrst_i(nrst_i), .sig_i(sig_i),
      .ext_ref_i(ref_cnt[3]), .ext_sel_i(ext_sel_i), .ext_freq_i(ext_freq_i),
      .src_rear_i(src_rear_i), .rst_btn_i(rst_btn_i), .dp_pos_i(dp_pos_i),
      .disp_o(disp), .lnk(lnk));
   sbc_host #(.NDIG(ND)) i_sbc_host (
      .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .start_i(start_i), .opt_en_i(opt_en),
      .rst_req_i(rst_req_i), .digits_o(digits), .dp_slot_o(dp_slot), .frame_o(frame),
      .latch_evt_o(latch_evt), .ovf_o(ovf_h), .gate_o(gate_h), .rst_seen_o(rst_seen), .lnk(lnk));
   sbc_asserts #(.NDIG(ND)) i_sbc_asserts (
      .clk_sys_i(clk_sys_i), .clk_link_i(clk_link_i), .nrst_i(nrst_i),
      .scan_clk(lnk.scan_clk), .scan_frame_marker(lnk.scan_frame_marker), .bcd(lnk.bcd),
      .dp(lnk.dp), .data_good(lnk.data_good), .gate(lnk.gate), .rst_line(lnk.rst_line));
   // ==========================================================
   // helpers
   function automatic logic [4*ND-1:0] to_bcd(input int v);
      logic [4*ND-1:0] r;
      r = '0;
      for (int k = 0; k < ND; k++) begin
         r[4*k +: 4] = 4'(v % 10);
         v = v / 10;
      end
      return r;
   endfunction
   task automatic check_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic check_near(input string nm, input int exp, input int got, input int tol);
      comparisons++;
      if (got < exp - tol || got > exp + tol) begin
         failures++;
         $display("wrong value %s expected %0d seen %0d", nm, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   // waits on a negative edge: 0 gate, 1 latch pulse, 2 frame pulse, 3 latch event
   task automatic wait_pin(input int w, input logic lvl, output int c);
      for (c = 0; c < 4000; c++) begin
         if ((w == 0 ? lnk.gate : w == 1 ? lnk.data_good : w == 2 ? frame : latch_evt) === lvl)
            break;
         @(negedge clk_sys_i);
      end
   endtask
   task automatic frames(input int n);
      int c;
      repeat (n) begin
         wait_pin(2, 1'b1, c);
         @(negedge clk_sys_i);
      end
   endtask
   task automatic meas(output int gap, output int gl, output int dl);
      wait_pin(0, 1'b1, gap);
      wait_pin(0, 1'b0, gl);
      wait_pin(1, 1'b0, dl);
   endtask
   task automatic test_done();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 40000) begin
         failures++;
         test_done();
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      int gap, gl, dl, n, dpv;
      int wt [3] = '{10, 2, 1};
      void'($urandom(95100));
      tick(40);
      nrst_i <= 1'b1;
      tick(60);
      @(negedge clk_sys_i);
      check_val("power-up pull", 32'h0, 32'(lnk.rst_line));
      tick(140);
      @(negedge clk_sys_i);
      check_val("power-up end", 32'h1, 32'(lnk.rst_line));
      check_val("identify", 32'h0, 32'(lnk.cnt_ident));
      for (int it = 0; it < 4; it++) begin
         n = (it == 0) ? 0 : (it == 1) ? 20 : 1 + $urandom % 19;
         dpv = $urandom % (ND + 1);
         tick(1);
         dp_pos_i <= 4'(dpv);
         start_i <= 1'b1;
         wait_pin(0, 1'b1, gap);
         check_val("dev pull", 32'h0, 32'(lnk.rst_dev_oe));
         tick(10);
         start_i <= 1'b0;
         @(negedge clk_sys_i);
         check_val("host gate", 32'h1, 32'(gate_h));
         check_val("option off", 32'h1, 32'(lnk.opt_gate));
         tick(1);
         repeat (n) begin
            sig_i <= 1'b1;
            tick(4);
            sig_i <= 1'b0;
            tick(4);
         end
         wait_pin(1, 1'b0, gap);
         check_val("display", 32'(to_bcd(n)), 32'(disp));
         check_val("overflow", 32'h0, 32'(lnk.ovf));
         wait_pin(3, 1'b1, gap);
         check_near("latch event", 3, gap, 1);
         check_val("host overflow", 32'h0, 32'(ovf_h));
         frames(2);
         check_val("digits", 32'(to_bcd(n)), 32'(digits));
         check_val("point slot", 32'(dpv), 32'(dp_slot));
         check_val("single shot", 32'h0, 32'(lnk.gate));
      end
      tick(1);
      start_i <= 1'b1;
      meas(gap, gl, dl);
      check_near("gate length", GT * TB_ACC_MOD / TB_ACC_ADD - 6, gl, 8);
      check_near("display time", 50, dl, 3);
      meas(gap, gl, dl);
      check_near("restart gap", 3, gap, 3);
      tick(1);
      start_i <= 1'b0;
      src_rear_i <= 1'b0;
      tick(6);
      @(negedge clk_sys_i);
      check_val("identify", 32'h1, 32'(lnk.cnt_ident));
      wait_pin(0, 1'b1, gap);
      tick(10 + $urandom % 200);
      rst_req_i <= 1'b1;
      tick(20);
      @(negedge clk_sys_i);
      check_val("abort gate", 32'h0, 32'(lnk.gate));
      check_val("abort pulse", 32'h0, 32'(lnk.data_good));
      check_val("line seen", 32'h1, 32'(rst_seen));
      tick(1);
      rst_req_i <= 1'b0;
      rst_btn_i <= 1'b1;
      tick(4);
      @(negedge clk_sys_i);
      check_val("button pull", 32'h0, 32'(lnk.rst_line));
      tick(1);
      rst_btn_i <= 1'b0;
      ext_sel_i <= 1'b1;
      for (int f = 0; f < 3; f++) begin
         tick(1);
         ext_freq_i <= sbc_ext_e'(f);
         meas(gap, gl, dl);
         meas(gap, gl, dl);
         check_near("ext gate", (GT / wt[f]) * 16 - 8, gl, 12);
      end
      tick(1);
      opt_en <= 1'b1;
      wait_pin(0, 1'b1, gap);
      tick(3);
      @(negedge clk_sys_i);
      check_val("option gate", 32'h0, 32'(lnk.opt_gate));
      check_val("option identify", 32'h0, 32'(lnk.opt_ident));
      tick(1);
      src_rear_i <= 1'b1;
      wait_pin(1, 1'b0, gap);
      tick(4);
      @(negedge clk_sys_i);
      check_val("option idle", 32'h1, 32'(lnk.opt_gate));
      check_val("on command", 32'h1, 32'(lnk.opt_ident));
      check_val("no start", 32'h0, 32'(lnk.gate));
      tick(1);
      start_i <= 1'b1;
      tick(2);
      @(negedge clk_sys_i);
      check_val("option start", 32'h0, 32'(lnk.opt_gate));
      check_val("gate not yet", 32'h0, 32'(lnk.gate));
      test_done();
   end
endmodule // scanned_bcd_counter_output_bench
